// ### src/sat_defs.svh
`ifndef SAT_DEFS_SVH
`define SAT_DEFS_SVH

// register addresses
`define SAT_ADDR_UNLOCK1    8'hD0
`define SAT_ADDR_UNLOCK2    8'hD1
`define SAT_ADDR_FINE_TRIM  8'h90
`define SAT_ADDR_TEMP_L_LO  8'hA0
`define SAT_ADDR_TEMP_L_HI  8'hA1
`define SAT_ADDR_TEMP_R_LO  8'hA2
`define SAT_ADDR_TEMP_R_HI  8'hA3
`define SAT_ADDR_OVERRIDE   8'hD6
`define SAT_ADDR_RANGE      8'hD7

// unlock keys
`define SAT_KEY1            8'h4A
`define SAT_KEY2            8'h66

// reset values
`define SAT_RST_OVERRIDE    8'h20
`define SAT_RST_FINE_TRIM   8'h00
`define SAT_RST_RANGE       8'h00

// field positions in the override register
`define SAT_BIT_AMP_EN      3
`define SAT_BIT_AMP_DIFF    2
`define SAT_BIT_REG5V_OFF   1
`define SAT_BIT_CP_OFF      0

// field widths
`define SAT_FINE_W          4
`define SAT_TEMP_W          13
`define SAT_TEMP_HI_W       5

`endif

// ### src/sat_pkg.sv
package sat_pkg;
  typedef enum logic [2:0] {
    SAT_LOCKED  = 3'h1,
    SAT_KEY1_OK = 3'h2,
    SAT_OPEN    = 3'h4
  } sat_lock_t;
endpackage

// ### src/sat_regs.sv
`timescale 1ns/100ps
`include "sat_defs.svh"

// Notes on behaviour
// [RULE_01] Unlock: write 0x4A to 0xD0, then 0x66 to 0xD1, then write 0xD6.
// [RULE_02] Any other access between unlock steps aborts the sequence.
// [RULE_03] After the protected write the override register relocks automatically.
// [RULE_04] Bit 3 enables the amplifier mode selection; when 0 the selection is ignored.
// [RULE_05] Bit 2 picks differential (1) or single-ended (0) output when enabled.
// [RULE_06] Bit 1 set powers down the 5V regulator; reset leaves it on.
// [RULE_07] Bit 0 set switches the charge pump off; reset leaves it on.
// [RULE_08] Host must not select single-ended mode on differential-only variants.
// [RULE_09] Fine trim bits 3:0 signed step count -8..+7, reset zero.
// [RULE_10] Coarse range bit 0 raises oscillator by about 25 percent, reset zero.
// [RULE_11] Reading any temperature register freezes all four until all are read.
// [RULE_12] Freeze releases once all four are read, in any order.
// [RULE_13] Temperatures are 13-bit read-only, low byte plus five bits high.
// [RULE_14] Override writes without the complete preceding unlock leave it unchanged.
module sat_regs
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  input  wire logic [7:0]              regAddr,
  input  wire logic [7:0]              regWdata,
  output logic      [7:0]              regRdata,
  input  wire logic [`SAT_TEMP_W-1:0]  tempLeftIn,
  input  wire logic [`SAT_TEMP_W-1:0]  tempRightIn,
  output logic                         ampModeOverrideEnable,
  output logic                         videoOutputDifferential,
  output logic                         ampDifferentialSelect,
  output logic                         regulator5vOff,
  output logic                         chargePumpOff,
  output logic signed [`SAT_FINE_W-1:0] oscFineAdjust,
  output logic                         oscCoarseBoost,
  output sat_pkg::sat_lock_t           lockState
);
  import sat_pkg::*;

  localparam logic [7:0] FineRst  = `SAT_RST_FINE_TRIM;
  localparam logic [7:0] RangeRst = `SAT_RST_RANGE;

  // register state and next values
  logic [7:0]             overrideReg;
  logic [7:0]             overrideNext;
  logic [`SAT_FINE_W-1:0] fineReg;
  logic [`SAT_FINE_W-1:0] fineNext;
  logic                   rangeReg;
  logic                   rangeNext;
  logic [`SAT_TEMP_W-1:0] tempLeftReg;
  logic [`SAT_TEMP_W-1:0] tempLeftNext;
  logic [`SAT_TEMP_W-1:0] tempRightReg;
  logic [`SAT_TEMP_W-1:0] tempRightNext;
  logic [3:0]             tempReadReg;
  logic [3:0]             tempReadNext;
  logic                   frozenReg;
  logic                   frozenNext;
  logic [7:0]             rdataNext;
  sat_lock_t              lockReg;
  sat_lock_t              lockNext;
  logic                   access;
  logic                   tempHit;
  logic [3:0]             tempSel;
  logic                   keyOneSeen;
  logic                   keyTwoSeen;
  logic                   overrideWrite;
  logic                   fineWrite;
  logic                   rangeWrite;
  logic                   captureLive;

  // one-hot select of the four temperature result addresses
  function automatic logic [3:0] tempDecode(input logic [7:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    case (addr)
      `SAT_ADDR_TEMP_L_LO: sel = 4'h1;
      `SAT_ADDR_TEMP_L_HI: sel = 4'h2;
      `SAT_ADDR_TEMP_R_LO: sel = 4'h4;
      `SAT_ADDR_TEMP_R_HI: sel = 4'h8;
      default:             sel = 4'h0;
    endcase
    return sel;
  endfunction

  // true for a write that carries the given key to the given unlock address;
  // both data and address must match, a right key at a wrong address is no key
  function automatic logic keyMatch
  (
    input logic       wr,
    input logic [7:0] addr,
    input logic [7:0] data,
    input logic [7:0] keyAddr,
    input logic [7:0] key
  );
    return wr && (addr == keyAddr) && (data == key);
  endfunction

  // low byte of a temperature result
  function automatic logic [7:0] lowByte(input logic [`SAT_TEMP_W-1:0] value);
    return value[7:0];
  endfunction

  // upper three bits of a high temperature byte always read as zero
  function automatic logic [7:0] highByte(input logic [`SAT_TEMP_W-1:0] value);
    return {3'h0, value[`SAT_TEMP_W-1:8]};
  endfunction

  assign access        = regWrite | regRead;
  assign tempSel       = tempDecode(regAddr);
  assign tempHit       = regRead & (tempSel != 4'h0);
  assign keyOneSeen    = keyMatch(regWrite, regAddr, regWdata,
                                  `SAT_ADDR_UNLOCK1, `SAT_KEY1); // RULE_01
  assign keyTwoSeen    = keyMatch(regWrite, regAddr, regWdata,
                                  `SAT_ADDR_UNLOCK2, `SAT_KEY2); // RULE_01
  assign overrideWrite = regWrite & (regAddr == `SAT_ADDR_OVERRIDE);
  assign fineWrite     = regWrite & (regAddr == `SAT_ADDR_FINE_TRIM);
  assign rangeWrite    = regWrite & (regAddr == `SAT_ADDR_RANGE);

  // unlock sequencer: any access that is not the expected next step drops back;
  // a read between the keys aborts too, so a stray poll cannot open the register
  always_comb
  begin
    lockNext = lockReg;
    if (access)
    begin
      case (lockReg)
        SAT_LOCKED:
          if (keyOneSeen)
            lockNext = SAT_KEY1_OK; // RULE_01
        SAT_KEY1_OK:
          if (keyTwoSeen)
            lockNext = SAT_OPEN; // RULE_01
          else
            lockNext = SAT_LOCKED; // RULE_02
        SAT_OPEN:
          lockNext = SAT_LOCKED; // RULE_02 RULE_03
        default:
          lockNext = SAT_LOCKED;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      lockReg <= SAT_LOCKED;
    else
      lockReg <= lockNext;
  end

  // protected register only moves when the open state meets a write to it
  always_comb
  begin
    overrideNext = overrideReg;
    if (overrideWrite && lockReg == SAT_OPEN)
      overrideNext = regWdata; // RULE_01 RULE_14
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      overrideReg <= `SAT_RST_OVERRIDE;
    else
      overrideReg <= overrideNext;
  end

  // only the trim field is stored, so the unused upper bits always read back zero
  always_comb
  begin
    fineNext = fineReg;
    if (fineWrite)
      fineNext = regWdata[`SAT_FINE_W-1:0]; // RULE_09
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      fineReg <= FineRst[`SAT_FINE_W-1:0]; // RULE_09
    else
      fineReg <= fineNext;
  end

  // coarse range keeps only bit 0
  always_comb
  begin
    rangeNext = rangeReg;
    if (rangeWrite)
      rangeNext = regWdata[0]; // RULE_10
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rangeReg <= RangeRst[0]; // RULE_10
    else
      rangeReg <= rangeNext;
  end

  // snapshot bookkeeping: a read of any temperature byte freezes all four
  always_comb
  begin
    tempReadNext = tempReadReg;
    if (tempHit)
      tempReadNext = tempReadReg | tempSel; // RULE_11
    if (tempReadNext == 4'hF)
      tempReadNext = 4'h0; // RULE_12
    frozenNext = (tempReadNext != 4'h0); // RULE_11 RULE_12
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tempReadReg <= 4'h0;
    else
      tempReadReg <= tempReadNext;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      frozenReg <= 1'b0;
    else
      frozenReg <= frozenNext;
  end

  // live values are captured only while no snapshot is pending; the first read
  // of a snapshot returns the value taken at the edge before it
  assign captureLive = !frozenReg && !tempHit; // RULE_11

  always_comb
  begin
    tempLeftNext  = tempLeftReg;
    tempRightNext = tempRightReg;
    if (captureLive)
    begin
      tempLeftNext  = tempLeftIn;
      tempRightNext = tempRightIn;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tempLeftReg <= '0;
    else
      tempLeftReg <= tempLeftNext;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tempRightReg <= '0;
    else
      tempRightReg <= tempRightNext;
  end

  // read data is registered and holds until the next read; unlock and unmapped
  // addresses return zero
  always_comb
  begin
    rdataNext = regRdata;
    if (regRead)
    begin
      case (regAddr)
        `SAT_ADDR_OVERRIDE:  rdataNext = overrideReg;
        `SAT_ADDR_FINE_TRIM: rdataNext = {4'h0, fineReg};
        `SAT_ADDR_RANGE:     rdataNext = {7'h00, rangeReg};
        `SAT_ADDR_TEMP_L_LO: rdataNext = lowByte(tempLeftReg); // RULE_13
        `SAT_ADDR_TEMP_L_HI: rdataNext = highByte(tempLeftReg); // RULE_13
        `SAT_ADDR_TEMP_R_LO: rdataNext = lowByte(tempRightReg); // RULE_13
        `SAT_ADDR_TEMP_R_HI: rdataNext = highByte(tempRightReg); // RULE_13
        default:             rdataNext = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else
      regRdata <= rdataNext;
  end

  // analog controls; differential-only parts rely on the host setting bits 3 and 2 and never clearing either
  assign ampModeOverrideEnable   = overrideReg[`SAT_BIT_AMP_EN]; // RULE_04
  assign ampDifferentialSelect   = overrideReg[`SAT_BIT_AMP_DIFF]; // RULE_05
  assign videoOutputDifferential = overrideReg[`SAT_BIT_AMP_EN]
                                   & overrideReg[`SAT_BIT_AMP_DIFF]; // RULE_04 RULE_05 RULE_08
  assign regulator5vOff          = overrideReg[`SAT_BIT_REG5V_OFF]; // RULE_06
  assign chargePumpOff           = overrideReg[`SAT_BIT_CP_OFF]; // RULE_07
  assign oscFineAdjust           = fineReg; // RULE_09
  assign oscCoarseBoost          = rangeReg; // RULE_10
  assign lockState               = lockReg;

endmodule

// ### testbench/sat_regs_properties.sv
`timescale 1ns/100ps
module sat_regs_properties
(
  input logic               ref_clk,
  input logic               rst_n,
  input logic               regWrite,
  input logic               regRead,
  input logic [7:0]         regAddr,
  input logic [7:0]         regWdata,
  input logic [7:0]         regRdata,
  input logic               ampModeOverrideEnable,
  input logic               ampDifferentialSelect,
  input logic               videoOutputDifferential,
  input logic               regulator5vOff,
  input logic               chargePumpOff,
  input logic signed [3:0]  oscFineAdjust,
  input sat_pkg::sat_lock_t lockState
);
  import sat_pkg::*;
  logic [7:0] ctl;
  assign ctl = {4'h0, ampModeOverrideEnable, ampDifferentialSelect, regulator5vOff, chargePumpOff};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_key; lockState == SAT_LOCKED && regWrite && regAddr == 8'hD0
    && regWdata == 8'h4A |=> lockState == SAT_KEY1_OK; endproperty
  a_key: assert property (p_key) else $error("key ignored");
  property p_abort; lockState == SAT_KEY1_OK && regRead |=> lockState == SAT_LOCKED; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_relock; lockState == SAT_OPEN && (regWrite || regRead) |=> lockState == SAT_LOCKED;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock");
  property p_wr; lockState == SAT_OPEN && regWrite && regAddr == 8'hD6
    |=> ctl == ($past(regWdata) & 8'h0F); endproperty
  a_wr: assert property (p_wr) else $error("override not written");
  property p_guard; lockState != SAT_OPEN && regWrite && regAddr == 8'hD6 |=> $stable(ctl);
  endproperty
  a_guard: assert property (p_guard) else $error("locked write taken");
  property p_vid; videoOutputDifferential == (ampModeOverrideEnable && ampDifferentialSelect);
  endproperty
  a_vid: assert property (p_vid) else $error("mode gating");
  property p_fine; regWrite && regAddr == 8'h90
    |=> {4'h0, oscFineAdjust} == ($past(regWdata) & 8'h0F); endproperty
  a_fine: assert property (p_fine) else $error("fine trim");
  property p_hi; regRead && (regAddr == 8'hA1 || regAddr == 8'hA3) |=> regRdata[7:5] == 3'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("high byte");
  c_open: cover property (lockState == SAT_OPEN && regWrite);
  c_abort: cover property (lockState == SAT_KEY1_OK && regRead);
  c_temp: cover property (regRead && regAddr == 8'hA2);
endmodule

// ### testbench/sat_host.sv
`timescale 1ns/100ps
module sat_host
(
  input  logic       ref_clk,
  output logic       regWrite,
  output logic       regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input  logic [7:0] regRdata
);
  initial {regWrite, regRead, regAddr, regWdata} = 18'h0;
  // released lines show inverted values so stale data never looks valid
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    {regWrite, regRead, regAddr, regWdata} <= {w, !w, a, d};
    @(posedge ref_clk);
    {regWrite, regRead, regAddr, regWdata} <= {2'h0, ~a, ~d};
    #1 q = regRdata;
  endtask
  // no other access may slip in between the three steps
  task prot(input logic [7:0] v);
    logic [7:0] q;
    acc(1'b1, 8'hD0, 8'h4A, q);
    acc(1'b1, 8'hD1, 8'h66, q);
    acc(1'b1, 8'hD6, v, q);
  endtask
endmodule

// ### testbench/sat_regs_tb.sv
`timescale 1ns/100ps
module sat_regs_tb;
  logic               ref_clk, rst_n, regWrite, regRead, oscCoarseBoost;
  logic               ampModeOverrideEnable, videoOutputDifferential, ampDifferentialSelect;
  logic               regulator5vOff, chargePumpOff;
  logic signed [3:0]  oscFineAdjust;
  logic [12:0]        tempLeftIn, tempRightIn;
  logic [7:0]         regAddr, regWdata, regRdata, ctl, q;
  sat_pkg::sat_lock_t lockState;
  int                 fails, compares;
  sat_regs sat_regs_inst (.ref_clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata,
    .regRdata, .tempLeftIn, .tempRightIn, .ampModeOverrideEnable, .videoOutputDifferential,
    .ampDifferentialSelect, .regulator5vOff, .chargePumpOff, .oscFineAdjust, .oscCoarseBoost,
    .lockState);
  sat_host sat_host_inst (.ref_clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata);
  assign ctl = {3'h0, videoOutputDifferential, ampModeOverrideEnable, ampDifferentialSelect,
    regulator5vOff, chargePumpOff};
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input string n);
    sat_host_inst.acc(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sat_host_inst.acc(1'b1, a, d, q);
  endtask
  task close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task t_reset;
    chk("ctl", 8'h00, ctl);
    rd(8'hD6, 8'h20, "ovr");
    rd(8'h90, 8'h00, "fine");
    rd(8'hD7, 8'h00, "range");
    $display("reset test done");
  endtask
  task t_lock;
    sat_host_inst.prot(8'h23);
    chk("ctl", 8'h03, ctl);
    wr(8'hD6, 8'h2E);
    rd(8'hD6, 8'h23, "ovr");
    wr(8'hD0, 8'h4A);
    rd(8'hD7, 8'h00, "range");
    wr(8'hD1, 8'h66);
    wr(8'hD6, 8'h2C);
    chk("ctl", 8'h03, ctl);
    sat_host_inst.prot(8'h2C);
    chk("ctl", 8'h1C, ctl);
    sat_host_inst.prot(8'h24);
    chk("ctl", 8'h04, ctl);
    $display("lock test done");
  endtask
  task t_trim;
    wr(8'h90, 8'h08);
    chk("fine", 8'h08, {4'h0, oscFineAdjust});
    rd(8'h90, 8'h08, "fine");
    wr(8'h90, 8'h07);
    chk("fine", 8'h07, {4'h0, oscFineAdjust});
    wr(8'hD7, 8'h01);
    chk("boost", 8'h01, {7'h0, oscCoarseBoost});
    $display("trim test done");
  endtask
  task t_temp;
    {tempLeftIn, tempRightIn} <= {13'h1ABC, 13'h0123};
    rd(8'hA1, 8'h1A, "lhi");
    {tempLeftIn, tempRightIn} <= {13'h0555, 13'h1FFF};
    rd(8'hA0, 8'hBC, "llo");
    rd(8'hA3, 8'h01, "rhi");
    rd(8'hA2, 8'h23, "rlo");
    rd(8'hA0, 8'h55, "llo");
    rd(8'hA3, 8'h1F, "rhi");
    $display("temp test done");
  endtask
  initial
  begin
    {fails, compares} = 0;
    {rst_n, tempLeftIn, tempRightIn} = 27'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    t_reset;
    t_lock;
    t_trim;
    t_temp;
    close_out;
  end
endmodule
bind sat_regs sat_regs_properties sat_regs_properties_inst (.ref_clk, .rst_n, .regWrite,
  .regRead, .regAddr, .regWdata, .regRdata, .ampModeOverrideEnable, .ampDifferentialSelect,
  .videoOutputDifferential, .regulator5vOff, .chargePumpOff, .oscFineAdjust, .lockState);
